// ---- wcm_top.sv ----
// Window comparator messages for digital outputs, Avalon-MM register slave
//
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/1ns
`include "wcm_params.svh"
module wcm_top
  import wcm_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Avalon-MM slave
  input  wire logic [7:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  // Measurements from datapath
  input  wire wcm_meas_type meas,
  // Messages
  output wcm_msg_type       msg,
  output logic              speed_above_thr,
  output logic              irq
);
  logic [31:0]        torq_cmp_r;
  logic [31:0]        torq_win_r;
  logic [3:0]         filt_tc_r;
  logic [31:0]        spd_cmp_r;
  logic [31:0]        spd_win_r;
  logic [15:0]        spd_dly_r;
  logic [31:0]        spd_thr_r;
  logic [31:0]        tgt_neg_r;
  logic [31:0]        tgt_pos_r;
  logic [15:0]        tgt_dly_r;
  logic [31:0]        fe_neg_r;
  logic [31:0]        fe_pos_r;
  logic [15:0]        fe_dly_r;
  logic [3:0]         irq_stat_r;
  logic [3:0]         irq_mask_r;
  logic               ack_r;
  logic [15:0]        sample_cnt_r;
  logic [7:0]         ms_cnt_r;
  logic               sample_en;
  logic               ms_tick;
  logic signed [31:0] cur_filt;
  logic               spd_in;
  logic               tgt_in;
  logic               fe_out;
  logic               spd_q;
  logic               tgt_q;
  logic               fe_q;
  wcm_msg_type        msg_prev_r;
  logic [3:0]         rise;
  logic               wr_en;
  logic               rd_en;
  logic [31:0]        rd_nxt;

  // Lower and upper bounds are widened to avoid wrap at the range ends
  function automatic logic in_window(input logic signed [31:0] x,
                                     input logic signed [31:0] centre,
                                     input logic [31:0]        below,
                                     input logic [31:0]        above);
    logic signed [33:0] lo;
    logic signed [33:0] hi;
    logic signed [33:0] xs;
    lo = {{2{centre[31]}}, centre} - {2'b00, below};
    hi = {{2{centre[31]}}, centre} + {2'b00, above};
    xs = {{2{x[31]}}, x};
    return (xs >= lo) && (xs <= hi);
  endfunction : in_window

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  // Bus handshake: every access answers on the second cycle
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign wr_en           = avs_write && ack_r;
  assign rd_en           = avs_read && !ack_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end

  // Sample and millisecond enables
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sample_cnt_r <= 16'h0000;
      ms_cnt_r     <= 8'h00;
    end else if (sample_en) begin
      sample_cnt_r <= 16'h0000;
      ms_cnt_r     <= ms_tick ? 8'h00 : ms_cnt_r + 8'h01;
    end else begin
      sample_cnt_r <= sample_cnt_r + 16'h0001;
    end
  end
  assign sample_en = (sample_cnt_r == 16'(`WCM_SAMPLE_CYC - 1));
  assign ms_tick   = sample_en && (ms_cnt_r == 8'(`WCM_MS_SAMPLES - 1));

  // Configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      torq_cmp_r <= `WCM_RST_WORD;
      torq_win_r <= `WCM_RST_WORD;
      filt_tc_r  <= `WCM_RST_FILT_TC;
      spd_cmp_r  <= `WCM_RST_WORD;
      spd_win_r  <= `WCM_RST_WORD;
      spd_dly_r  <= `WCM_RST_DLY;
      spd_thr_r  <= `WCM_RST_WORD;
      tgt_neg_r  <= `WCM_RST_WORD;
      tgt_pos_r  <= `WCM_RST_WORD;
      tgt_dly_r  <= `WCM_RST_DLY;
      fe_neg_r   <= `WCM_RST_WORD;
      fe_pos_r   <= `WCM_RST_WORD;
      fe_dly_r   <= `WCM_RST_DLY;
      irq_mask_r <= 4'h0;
    end else if (wr_en) begin
      unique case (avs_address)
        `WCM_OFS_TORQ_CMP: torq_cmp_r <= merge(torq_cmp_r, avs_writedata, avs_byteenable);
        `WCM_OFS_TORQ_WIN: torq_win_r <= merge(torq_win_r, avs_writedata, avs_byteenable);
        `WCM_OFS_FILT_TC:  if (avs_byteenable[0]) filt_tc_r <= avs_writedata[3:0];
        `WCM_OFS_SPD_CMP:  spd_cmp_r  <= merge(spd_cmp_r, avs_writedata, avs_byteenable);
        `WCM_OFS_SPD_WIN:  spd_win_r  <= merge(spd_win_r, avs_writedata, avs_byteenable);
        `WCM_OFS_SPD_DLY:  spd_dly_r  <= 16'(merge({16'h0000, spd_dly_r}, avs_writedata, avs_byteenable));
        `WCM_OFS_SPD_THR:  spd_thr_r  <= merge(spd_thr_r, avs_writedata, avs_byteenable);
        `WCM_OFS_TGT_NEG:  tgt_neg_r  <= merge(tgt_neg_r, avs_writedata, avs_byteenable);
        `WCM_OFS_TGT_POS:  tgt_pos_r  <= merge(tgt_pos_r, avs_writedata, avs_byteenable);
        `WCM_OFS_TGT_DLY:  tgt_dly_r  <= 16'(merge({16'h0000, tgt_dly_r}, avs_writedata, avs_byteenable));
        `WCM_OFS_FE_NEG:   fe_neg_r   <= merge(fe_neg_r, avs_writedata, avs_byteenable);
        `WCM_OFS_FE_POS:   fe_pos_r   <= merge(fe_pos_r, avs_writedata, avs_byteenable);
        `WCM_OFS_FE_DLY:   fe_dly_r   <= 16'(merge({16'h0000, fe_dly_r}, avs_writedata, avs_byteenable));
        `WCM_OFS_IRQ_MASK: if (avs_byteenable[0]) irq_mask_r <= avs_writedata[3:0];
        default: ;
      endcase
    end
  end

  // Current filter
  wcm_pt1 u_pt1 (
    .clk       (clk),
    .rst       (rst),
    .sample_en (sample_en),
    .tc_shift  (filt_tc_r),
    .din       (meas.current),
    .dout      (cur_filt)
  );

  // Window conditions
  assign spd_in = in_window(meas.speed, spd_cmp_r, spd_win_r, spd_win_r);
  assign tgt_in = in_window(meas.pos_act, meas.pos_target, tgt_neg_r, tgt_pos_r);
  // Own limits only; shutdown threshold lives elsewhere
  assign fe_out = !in_window(meas.pos_act, meas.pos_set, fe_neg_r, fe_pos_r);

  wcm_qual u_spd_qual (
    .clk      (clk),
    .rst      (rst),
    .ms_tick  (ms_tick),
    .delay_ms (spd_dly_r),
    .cond     (spd_in),
    .qual     (spd_q)
  );

  // Window follows the live target, so a new run in range keeps the message
  wcm_qual u_tgt_qual (
    .clk      (clk),
    .rst      (rst),
    .ms_tick  (ms_tick),
    .delay_ms (tgt_dly_r),
    .cond     (tgt_in),
    .qual     (tgt_q)
  );

  wcm_qual u_fe_qual (
    .clk      (clk),
    .rst      (rst),
    .ms_tick  (ms_tick),
    .delay_ms (fe_dly_r),
    .cond     (fe_out),
    .qual     (fe_q)
  );

  // Message outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      msg             <= '0;
      speed_above_thr <= 1'b0;
    end else begin
      msg.torque      <= in_window(cur_filt, torq_cmp_r, torq_win_r, torq_win_r);
      msg.speed       <= spd_q;
      msg.target      <= tgt_q;
      msg.ferr        <= fe_q;
      speed_above_thr <= ($signed(meas.speed) >= $signed(spd_thr_r));
    end
  end

  // Interrupt status: rising message edges, set wins over write-one clear
  assign rise = msg & ~msg_prev_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      msg_prev_r <= '0;
      irq_stat_r <= 4'h0;
    end else begin
      msg_prev_r <= msg;
      if (wr_en && avs_address == `WCM_OFS_IRQ_STAT && avs_byteenable[0]) begin
        irq_stat_r <= (irq_stat_r & ~avs_writedata[3:0]) | rise;
      end else begin
        irq_stat_r <= irq_stat_r | rise;
      end
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // Read mux; unmapped offsets read zero
  always_comb begin
    unique case (avs_address)
      `WCM_OFS_TORQ_CMP: rd_nxt = torq_cmp_r;
      `WCM_OFS_TORQ_WIN: rd_nxt = torq_win_r;
      `WCM_OFS_FILT_TC:  rd_nxt = {28'h0000000, filt_tc_r};
      `WCM_OFS_SPD_CMP:  rd_nxt = spd_cmp_r;
      `WCM_OFS_SPD_WIN:  rd_nxt = spd_win_r;
      `WCM_OFS_SPD_DLY:  rd_nxt = {16'h0000, spd_dly_r};
      `WCM_OFS_SPD_THR:  rd_nxt = spd_thr_r;
      `WCM_OFS_TGT_NEG:  rd_nxt = tgt_neg_r;
      `WCM_OFS_TGT_POS:  rd_nxt = tgt_pos_r;
      `WCM_OFS_TGT_DLY:  rd_nxt = {16'h0000, tgt_dly_r};
      `WCM_OFS_FE_NEG:   rd_nxt = fe_neg_r;
      `WCM_OFS_FE_POS:   rd_nxt = fe_pos_r;
      `WCM_OFS_FE_DLY:   rd_nxt = {16'h0000, fe_dly_r};
      `WCM_OFS_STATUS:   rd_nxt = {27'h0000000, speed_above_thr, msg};
      `WCM_OFS_IRQ_STAT: rd_nxt = {28'h0000000, irq_stat_r};
      `WCM_OFS_IRQ_MASK: rd_nxt = {28'h0000000, irq_mask_r};
      `WCM_OFS_FILT_CUR: rd_nxt = cur_filt;
      default:           rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (rd_en) begin
      avs_readdata <= rd_nxt;
    end
  end
endmodule : wcm_top

// ---- wcm_params.svh ----
// Register offsets, reset values and timing counts of the window comparator
`ifndef WCM_PARAMS_SVH
`define WCM_PARAMS_SVH

`define WCM_OFS_TORQ_CMP   8'h00
`define WCM_OFS_TORQ_WIN   8'h04
`define WCM_OFS_FILT_TC    8'h08
`define WCM_OFS_SPD_CMP    8'h0c
`define WCM_OFS_SPD_WIN    8'h10
`define WCM_OFS_SPD_DLY    8'h14
`define WCM_OFS_SPD_THR    8'h18
`define WCM_OFS_TGT_NEG    8'h1c
`define WCM_OFS_TGT_POS    8'h20
`define WCM_OFS_TGT_DLY    8'h24
`define WCM_OFS_FE_NEG     8'h28
`define WCM_OFS_FE_POS     8'h2c
`define WCM_OFS_FE_DLY     8'h30
`define WCM_OFS_STATUS     8'h34
`define WCM_OFS_IRQ_STAT   8'h38
`define WCM_OFS_IRQ_MASK   8'h3c
`define WCM_OFS_FILT_CUR   8'h40

`define WCM_BIT_TORQ       0
`define WCM_BIT_SPD        1
`define WCM_BIT_TGT        2
`define WCM_BIT_FE         3
`define WCM_BIT_THR        4

`define WCM_RST_WORD       32'h0000_0000
`define WCM_RST_FILT_TC    4'h4
`define WCM_RST_DLY        16'h0001

`define WCM_CLK_NS         50
`define WCM_SAMPLE_NS      50000
`define WCM_SAMPLE_CYC     ((`WCM_SAMPLE_NS + `WCM_CLK_NS - 1) / `WCM_CLK_NS)
`define WCM_MS_NS          1000000
`define WCM_MS_SAMPLES     (`WCM_MS_NS / `WCM_SAMPLE_NS)

`endif

// ---- wcm_pkg.sv ----
// Types shared by the window comparator files
package wcm_pkg;
  typedef struct packed {
    logic signed [31:0] current;
    logic signed [31:0] speed;
    logic signed [31:0] pos_act;
    logic signed [31:0] pos_target;
    logic signed [31:0] pos_set;
  } wcm_meas_type;

  typedef struct packed {
    logic ferr;
    logic target;
    logic speed;
    logic torque;
  } wcm_msg_type;
endpackage : wcm_pkg

// ---- wcm_pt1.sv ----
// First-order lag low-pass filter with shift-coded time constant
`timescale 1ns/1ns
module wcm_pt1
  import wcm_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Sample enable and time constant
  input  wire logic               sample_en,
  input  wire logic [3:0]         tc_shift,
  // Data
  input  wire logic signed [31:0] din,
  output logic signed [31:0]      dout
);
  logic signed [32:0] diff;
  logic signed [32:0] step;

  always_comb begin
    diff = {din[31], din} - {dout[31], dout};
    step = diff >>> tc_shift;
  end

  // Larger shift means longer time constant; resolution lost below 2**shift
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dout <= 32'sh0000_0000;
    end else if (sample_en) begin
      dout <= 32'(dout + step[31:0]);
    end
  end
endmodule : wcm_pt1

// ---- wcm_qual.sv ----
// Response-delay qualifier: condition must hold unbroken before output sets
`timescale 1ns/1ns
module wcm_qual
  import wcm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Millisecond tick and delay
  input  wire logic        ms_tick,
  input  wire logic [15:0] delay_ms,
  // Condition and qualified output
  input  wire logic        cond,
  output logic             qual
);
  logic [15:0] cnt_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 16'h0000;
      qual  <= 1'b0;
    end else if (!cond) begin
      cnt_r <= 16'h0000;
      qual  <= 1'b0;
    end else if (!qual) begin
      // First tick lands at any phase, so one extra tick keeps the wait at least the delay
      if (delay_ms == 16'h0000) begin
        qual <= 1'b1;
      end else if (ms_tick) begin
        if (cnt_r >= delay_ms) begin
          qual <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 16'h0001;
        end
      end
    end
  end
endmodule : wcm_qual

// ---- wcm_meas_src.sv ----
// Behavioural measurement datapath feeding the comparator
`timescale 1ns/1ns
module wcm_meas_src
  import wcm_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Measurements
  output wcm_meas_type meas
);
  initial meas = '0;
  // New sample lands just after an edge, as the real datapath does
  task automatic drive(input wcm_meas_type v);
    @(posedge clk);
    meas <= v;
  endtask : drive
endmodule : wcm_meas_src

// ---- wcm_assertions.sv ----
// Concurrent checks on the window comparator ports
`timescale 1ns/1ns
module wcm_chk
  import wcm_pkg::*;
(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Bus
  input  wire logic [7:0]   avs_address,
  input  wire logic         avs_read,
  input  wire logic         avs_write,
  input  wire logic [31:0]  avs_writedata,
  input  wire logic [3:0]   avs_byteenable,
  input  wire logic [31:0]  avs_readdata,
  input  wire logic         avs_waitrequest,
  // Datapath and messages
  input  wire wcm_meas_type meas,
  input  wire wcm_msg_type  msg,
  input  wire logic         speed_above_thr,
  input  wire logic         irq
);
  logic signed [31:0] cfg_r [16];
  logic               spd_in, tgt_in, fe_out, thr_ge;
  // Shadow of the config words, lanes as the slave takes them
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) cfg_r[i] <= '0;
    end else if (avs_write && !avs_waitrequest && avs_address[7:6] == 2'h0) begin
      for (int b = 0; b < 4; b++) if (avs_byteenable[b]) cfg_r[avs_address[5:2]][8*b +: 8] <= avs_writedata[8*b +: 8];
    end
  end
  assign spd_in = meas.speed >= cfg_r[3] - cfg_r[4] && meas.speed <= cfg_r[3] + cfg_r[4];
  assign tgt_in = meas.pos_act >= meas.pos_target - cfg_r[7] && meas.pos_act <= meas.pos_target + cfg_r[8];
  assign fe_out = meas.pos_act < meas.pos_set - cfg_r[10] || meas.pos_act > meas.pos_set + cfg_r[11];
  assign thr_ge = meas.speed >= cfg_r[6];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait longer than one cycle");
  AST_IDLE_READY: assert property (!avs_read && !avs_write |-> !avs_waitrequest)
    else $error("wait without request");
  AST_IRQ_MASKED: assert property (cfg_r[15][3:0] == 4'h0 |-> !irq)
    else $error("irq with mask clear");
  AST_SPD_DROP: assert property (!spd_in |-> ##2 !msg.speed)
    else $error("speed message outlives window");
  AST_SPD_RISE: assert property ($rose(msg.speed) |-> $past(spd_in, 2))
    else $error("speed message without window");
  AST_TGT_FELL: assert property ($fell(msg.target) |-> !$past(tgt_in, 2))
    else $error("target message fell inside window");
  AST_TGT_DROP: assert property (!tgt_in |-> ##2 !msg.target)
    else $error("target message outside window");
  AST_FE_RISE: assert property ($rose(msg.ferr) |-> $past(fe_out, 2))
    else $error("follow message inside window");
  AST_FE_DROP: assert property (!fe_out |-> ##2 !msg.ferr)
    else $error("follow message outlives error");
  AST_THR: assert property (!rst |=> speed_above_thr == $past(thr_ge))
    else $error("threshold flag wrong");
endmodule : wcm_chk

bind wcm_top wcm_chk chk_u (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .meas(meas), .msg(msg),
  .speed_above_thr(speed_above_thr), .irq(irq));

// ---- tb.sv ----
// Self-checking bench for the window comparator
`timescale 1ns/1ns
module tb
  import wcm_pkg::*;
;
  typedef struct {int s, a, t, p; logic [3:0] e;} wcm_row_type;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic [7:0]   avs_address = 8'h00;
  logic         avs_read = 1'b0;
  logic         avs_write = 1'b0;
  logic [31:0]  avs_writedata = 32'h0;
  logic [3:0]   avs_byteenable = 4'hf;
  logic [31:0]  avs_readdata, q;
  logic         avs_waitrequest, speed_above_thr, irq, hit;
  wcm_meas_type meas, cur;
  wcm_msg_type  msg;
  int           checks = 0;
  int           miscompares = 0;
  int           n;
  logic [7:0]   ra [4] = '{8'h08, 8'h14, 8'h3c, 8'h80};
  logic [31:0]  rv [4] = '{32'h4, 32'h1, 32'h0, 32'h0};
  logic [7:0]   ca [10] = '{8'h0c, 8'h10, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h14};
  logic [31:0]  cd [10] = '{32'd100, 32'd10, 32'd105, 32'd5, 32'd8, 32'd0, 32'd3, 32'd4, 32'd0, 32'd0};
  // Boundary values of each window, expected {thr, ferr, target, speed}
  wcm_row_type  rows [6] = '{'{90, 995, 1000, 995, 4'h3}, '{110, 1008, 1000, 1012, 4'hf},
    '{89, 1009, 1000, 1005, 4'h0}, '{111, 994, 1000, 990, 4'h8}, '{105, 1016, 1000, 1012, 4'h9},
    '{100, 999, 1000, 1003, 4'h7}};
  always #25 clk = ~clk;
  wcm_meas_src src_u (.clk(clk), .meas(meas));
  wcm_top dut_u (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .meas(meas), .msg(msg), .speed_above_thr(speed_above_thr), .irq(irq));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Request held until waitrequest is seen low at a rising edge; the watchdog ends a hang
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
                     output logic [31:0] rdat);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf, q);
  endtask : wreg
  task automatic rdck(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk(nm, q, e);
  endtask : rdck
  // Filter moves only once a sample period, so poll until it does
  task automatic filt_wait(input logic [31:0] old);
    int k;
    k = 0;
    do begin
      bus(1'b0, 8'h40, 32'h0, 4'hf, q);
      k++;
    end while (q === old && k < 500);
  endtask : filt_wait
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    test_done();
  end
  initial begin
    cur = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("irq_rst", irq, 32'h0);
    for (int i = 0; i < 4; i++) rdck("rst_val", ra[i], rv[i]);
    for (int i = 0; i < 10; i++) wreg(ca[i], cd[i]);
    for (int i = 0; i < 6; i++) begin
      cur.speed = rows[i].s;
      cur.pos_act = rows[i].a;
      cur.pos_target = rows[i].t;
      cur.pos_set = rows[i].p;
      src_u.drive(cur);
      repeat (4) @(negedge clk);
      chk("row", {speed_above_thr, msg[3:1]}, rows[i].e);
    end
    cur.pos_target = 992;
    src_u.drive(cur);
    hit = 1'b1;
    repeat (6) begin
      @(negedge clk);
      hit &= msg.target;
    end
    chk("tgt_keep", hit, 32'h1);
    cur.pos_target = 990;
    src_u.drive(cur);
    repeat (4) @(negedge clk);
    chk("tgt_leave", msg.target, 32'h0);
    rdck("irq_stat", 8'h38, 32'hf);
    chk("irq_off", irq, 32'h0);
    wreg(8'h3c, 32'h4);
    @(negedge clk);
    chk("irq_on", irq, 32'h1);
    wreg(8'h38, 32'hf);
    rdck("irq_clr", 8'h38, 32'h0);
    chk("irq_low", irq, 32'h0);
    bus(1'b1, 8'h18, 32'h1234_5600, 4'h1, q);
    rdck("thr_lane", 8'h18, 32'h0);
    wreg(8'h00, 32'd200);
    wreg(8'h04, 32'd20);
    wreg(8'h08, 32'h0);
    cur.current = 221;
    src_u.drive(cur);
    filt_wait(32'h0);
    chk("filt", q, 32'd221);
    repeat (2) @(negedge clk);
    chk("torq_out", msg.torque, 32'h0);
    wreg(8'h08, 32'h1);
    cur.current = 181;
    src_u.drive(cur);
    filt_wait(32'd221);
    chk("filt_lag", q, 32'd201);
    repeat (2) @(negedge clk);
    chk("torq_in", msg.torque, 32'h1);
    // One millisecond delay; an early drop must restart the wait
    wreg(8'h14, 32'h1);
    cur.speed = 0;
    src_u.drive(cur);
    repeat (4) @(negedge clk);
    cur.speed = 100;
    src_u.drive(cur);
    hit = 1'b0;
    repeat (15000) begin
      @(negedge clk);
      hit |= msg.speed;
    end
    cur.speed = 0;
    src_u.drive(cur);
    repeat (4) @(negedge clk);
    cur.speed = 100;
    src_u.drive(cur);
    repeat (19990) begin
      @(negedge clk);
      hit |= msg.speed;
    end
    chk("spd_early", hit, 32'h0);
    n = 0;
    while (msg.speed !== 1'b1 && n < 20100) begin
      @(negedge clk);
      n++;
    end
    chk("spd_late", msg.speed, 32'h1);
    test_done();
  end
endmodule : tb
